// ===== rtl/mcc_coil_ctrl.sv
`timescale 1ns/10ps
// Notes on behaviour
// - edge on 212/213 clears stored sequence table of axis A/B.
// - edge on 220/221 applies written common parameters to axis A/B.
// - edge on 224 loads all profiles; 225 loads the designated one.
// - edge on 226/227 loads the sequence table of axis A/B.
// - edge on 240/241 stops axis A/B at once, no ramp.
// - edge on 244/245 ramps axis A/B down, then stops.
// - coil 248/249 held high steers axis A/B to override rate.
// - edge on 252/253 starts registration-distance move on axis A/B.
// - edge on 256/257 switches profile of axis A/B in auto speed mode.
// - edge on 260/261 changes pulse speed of axis A/B.
// - edge on 264/265 adjusts output position count of axis A/B.
// - edge on 268/269 latches current position of axis A/B.
// - edge on 272/273 adjusts input position count of axis A/B.
// - level coil 292/293: one enters manual mode, zero cancels it.
// - edge on 300 or 310 starts free homing on axis A or B.
// - edges on 301/302, 311/312 start low-speed homing ccw/cw.
// - edges on 303/304, 313/314 start off-edge high-speed homing.
// - edges on 305/306, 315/316 start marker high-speed homing.
// - edges on 340/341, 344/345 run stored sequence once/continuously.
// - edges on 342/343, 346 run supplied sequence once/continuously.
// - writing one requests an action; every coil reads back.
// - only coil addresses 1 through 519 are decoded.
module mcc_coil_ctrl
  import mcc_pkg::*;
(
  input  wire logic               clk_in,        // system clock
  input  wire logic               rst_in,        // sync reset, high
  input  wire logic               wr_en_in,      // coil write strobe
  input  wire logic [COIL_AW-1:0] wr_addr_in,    // coil write address
  input  wire logic               wr_data_in,    // coil write value
  input  wire logic               rd_en_in,      // coil read strobe
  input  wire logic [COIL_AW-1:0] rd_addr_in,    // coil read address
  output logic                    rd_data_out,   // coil read value
  output logic                    rd_ack_out,    // read answered
  output logic                    wr_ack_out,    // write accepted
  output logic                    addr_err_out,  // address out of span
  output logic [N_EDGE-1:0]       act_pulse_out, // action pulses
  output logic                    fro_a_out,     // override axis a
  output logic                    fro_b_out,     // override axis b
  output logic                    manual_a_out,  // manual mode axis a
  output logic                    manual_b_out   // manual mode axis b
);

  // elaboration check on the table sizes
  if (COIL_MAX != int'(COIL_LAST) || COIL_AW < 10) begin : g_chk
    $error("coil span and address width disagree");
  end

  typedef struct packed {
    logic [N_EDGE-1:0] lvl;
    logic [N_LVL-1:0]  hold;
    logic              rd_ack;
    logic              wr_ack;
    logic              addr_err;
  } mcc_ctrl_state_type;

  mcc_ctrl_state_type q;
  mcc_ctrl_state_type next_q;

  mcc_link_if link ();

  logic              wr_ok;
  logic              rd_ok;
  logic [N_EDGE-1:0] edge_hit;
  logic [N_LVL-1:0]  lvl_hit;
  logic [N_EDGE-1:0] edge_wr;
  logic [N_LVL-1:0]  lvl_wr;

  // address span check for both strobes
  assign wr_ok = wr_addr_in >= COIL_FIRST &&
                 wr_addr_in <= COIL_LAST;
  assign rd_ok = rd_addr_in >= COIL_FIRST &&
                 rd_addr_in <= COIL_LAST;

  // match the write address against each action coil
  for (genvar i = 0; i < N_EDGE; i++) begin : g_edge_dec
    assign edge_hit[i] = wr_ok && wr_addr_in == EDGE_COIL[i];
  end

  // match the write address against each level coil
  for (genvar j = 0; j < N_LVL; j++) begin : g_lvl_dec
    assign lvl_hit[j] = wr_ok && wr_addr_in == LVL_COIL[j];
  end

  // only mapped coils reach the action logic
  assign edge_wr = wr_en_in ? edge_hit : '0;
  assign lvl_wr  = wr_en_in ? lvl_hit  : '0;

  // track coil levels and bus answers
  always_comb begin
    next_q = q;
    // action coil mirrors, edge found downstream
    next_q.lvl = (q.lvl & ~edge_wr) |
                 (edge_wr & {N_EDGE{wr_data_in}});
    // override and manual levels follow the written value
    next_q.hold = (q.hold & ~lvl_wr) |
                  (lvl_wr & {N_LVL{wr_data_in}});
    next_q.wr_ack   = wr_en_in && wr_ok;
    next_q.rd_ack   = rd_en_in;
    next_q.addr_err = (wr_en_in && !wr_ok) ||
                      (rd_en_in && !rd_ok);
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // coil storage for readback of every in-span address
  assign link.wr_en   = wr_en_in;
  assign link.wr_addr = wr_addr_in;
  assign link.wr_data = wr_data_in;
  assign link.rd_en   = rd_en_in;
  assign link.rd_addr = rd_addr_in;
  assign link.lvl     = q.lvl;

  mcc_coil_mem u_mem (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .link   (link.mem)
  );

  // rising-edge detection of the action coils
  mcc_edge_bank u_edge (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .link   (link.det)
  );

  // pulse vector: clear tables, set parameters, load data
  // stops, moves, speed, profile and position changes
  // homing variants and sequence runs
  assign act_pulse_out = link.rise;

  // registered outputs
  assign rd_data_out  = link.rd_data;
  assign rd_ack_out   = q.rd_ack;
  assign wr_ack_out   = q.wr_ack;
  assign addr_err_out = q.addr_err;
  assign fro_a_out    = q.hold[LVL_FRO_A];
  assign fro_b_out    = q.hold[LVL_FRO_B];
  assign manual_a_out = q.hold[LVL_MANUAL_A];
  assign manual_b_out = q.hold[LVL_MANUAL_B];

endmodule

// ===== rtl/mcc_pkg.sv
package mcc_pkg;

  // coil address width and decoded span
  localparam int          COIL_AW    = 16;
  localparam int          COIL_MAX   = 519;
  localparam logic [15:0] COIL_FIRST = 16'h0001;
  localparam logic [15:0] COIL_LAST  = 16'h0207;

  // edge-detected action coils
  localparam int N_EDGE = 45;
  localparam logic [15:0] EDGE_COIL [N_EDGE] = '{
    16'h00d4, 16'h00d5, 16'h00dc, 16'h00dd, 16'h00e0, 16'h00e1,
    16'h00e2, 16'h00e3, 16'h00f0, 16'h00f1, 16'h00f4, 16'h00f5,
    16'h00fc, 16'h00fd, 16'h0100, 16'h0101, 16'h0104, 16'h0105,
    16'h0108, 16'h0109, 16'h010c, 16'h010d, 16'h0110, 16'h0111,
    16'h012c, 16'h012d, 16'h012e, 16'h012f, 16'h0130, 16'h0131,
    16'h0132, 16'h0136, 16'h0137, 16'h0138, 16'h0139, 16'h013a,
    16'h013b, 16'h013c, 16'h0154, 16'h0155, 16'h0156, 16'h0157,
    16'h0158, 16'h0159, 16'h015a
  };

  // bit positions of the action pulse vector
  localparam int ACT_CLR_SEQ_A    = 0;
  localparam int ACT_CLR_SEQ_B    = 1;
  localparam int ACT_SET_PAR_A    = 2;
  localparam int ACT_SET_PAR_B    = 3;
  localparam int ACT_LD_PROF_ALL  = 4;
  localparam int ACT_LD_PROF_ONE  = 5;
  localparam int ACT_LD_SEQ_A     = 6;
  localparam int ACT_LD_SEQ_B     = 7;
  localparam int ACT_STOP_A       = 8;
  localparam int ACT_STOP_B       = 9;
  localparam int ACT_DECEL_A      = 10;
  localparam int ACT_DECEL_B      = 11;
  localparam int ACT_REG_MOVE_A   = 12;
  localparam int ACT_REG_MOVE_B   = 13;
  localparam int ACT_CHG_PROF_A   = 14;
  localparam int ACT_CHG_PROF_B   = 15;
  localparam int ACT_CHG_SPD_A    = 16;
  localparam int ACT_CHG_SPD_B    = 17;
  localparam int ACT_ADJ_OPOS_A   = 18;
  localparam int ACT_ADJ_OPOS_B   = 19;
  localparam int ACT_LATCH_POS_A  = 20;
  localparam int ACT_LATCH_POS_B  = 21;
  localparam int ACT_ADJ_IPOS_A   = 22;
  localparam int ACT_ADJ_IPOS_B   = 23;
  localparam int ACT_HOME_A       = 24; // 24..30: free, low ccw/cw,
  localparam int ACT_HOME_B       = 31; // off-edge ccw/cw, marker ccw/cw
  localparam int ACT_SEQ_A        = 38; // stored once/loop, supplied once/loop
  localparam int ACT_SEQ_B        = 42; // stored once/loop, supplied once

  // level-sensitive coils
  localparam int N_LVL = 4;
  localparam logic [15:0] LVL_COIL [N_LVL] = '{
    16'h00f8, 16'h00f9, 16'h0124, 16'h0125
  };
  localparam int LVL_FRO_A    = 0;
  localparam int LVL_FRO_B    = 1;
  localparam int LVL_MANUAL_A = 2;
  localparam int LVL_MANUAL_B = 3;

endpackage

// ===== rtl/mcc_link_if.sv
`timescale 1ns/10ps
interface mcc_link_if;
  import mcc_pkg::*;

  logic                wr_en;
  logic [COIL_AW-1:0]  wr_addr;
  logic                wr_data;
  logic                rd_en;
  logic [COIL_AW-1:0]  rd_addr;
  logic                rd_data;
  logic [N_EDGE-1:0]   lvl;
  logic [N_EDGE-1:0]   rise;

  modport top  (output wr_en, wr_addr, wr_data, rd_en, rd_addr, lvl,
                input  rd_data, rise);
  modport mem  (input  wr_en, wr_addr, wr_data, rd_en, rd_addr,
                output rd_data);
  modport det  (input  lvl,
                output rise);
endinterface

// ===== rtl/mcc_coil_mem.sv
`timescale 1ns/10ps
module mcc_coil_mem
  import mcc_pkg::*;
(
  input  wire logic clk_in,   // system clock
  input  wire logic rst_in,   // sync reset, active high
  mcc_link_if.mem   link      // coil access
);

  typedef struct packed {
    logic [COIL_MAX:1] bits;
    logic              rd_data;
  } mcc_mem_state_type;

  mcc_mem_state_type q;
  mcc_mem_state_type next_q;

  // store any in-range coil, return the old value on reads
  always_comb begin
    next_q = q;
    if (link.wr_en && link.wr_addr >= COIL_FIRST &&
        link.wr_addr <= COIL_LAST) begin
      next_q.bits[link.wr_addr] = link.wr_data;
    end
    if (link.rd_en) begin
      if (link.rd_addr >= COIL_FIRST && link.rd_addr <= COIL_LAST) begin
        next_q.rd_data = q.bits[link.rd_addr];
      end else begin
        next_q.rd_data = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign link.rd_data = q.rd_data;

endmodule

// ===== rtl/mcc_edge_bank.sv
`timescale 1ns/10ps
module mcc_edge_bank
  import mcc_pkg::*;
(
  input  wire logic clk_in,   // system clock
  input  wire logic rst_in,   // sync reset, active high
  mcc_link_if.det   link      // coil levels in, pulses out
);

  typedef struct packed {
    logic [N_EDGE-1:0] prev;
    logic [N_EDGE-1:0] rise;
  } mcc_edge_state_type;

  mcc_edge_state_type q;
  mcc_edge_state_type next_q;
  logic [N_EDGE-1:0]  rise_w;

  // one pulse per 0-to-1 change of each action coil
  for (genvar i = 0; i < N_EDGE; i++) begin : g_edge
    assign rise_w[i] = link.lvl[i] & ~q.prev[i];
  end

  // next state
  always_comb begin
    next_q      = q;
    next_q.prev = link.lvl;
    next_q.rise = rise_w;
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign link.rise = q.rise;

endmodule

// ===== test/mcc_monitor.sv
`timescale 1ns/10ps
module mcc_monitor
  import mcc_pkg::*;
(
  input wire logic               clk_in,        // system clock
  input wire logic               rst_in,        // sync reset
  input wire logic               wr_en_in,      // write strobe
  input wire logic [COIL_AW-1:0] wr_addr_in,    // write address
  input wire logic               wr_data_in,    // write value
  input wire logic               rd_en_in,      // read strobe
  input wire logic [COIL_AW-1:0] rd_addr_in,    // read address
  input wire logic               rd_data_out,   // read value
  input wire logic               rd_ack_out,    // read answered
  input wire logic               wr_ack_out,    // write accepted
  input wire logic               addr_err_out,  // span error
  input wire logic [N_EDGE-1:0]  act_pulse_out, // action pulses
  input wire logic               fro_a_out,     // override a
  input wire logic               fro_b_out,     // override b
  input wire logic               manual_a_out,  // manual a
  input wire logic               manual_b_out   // manual b
);
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // write outside the span and its answer
  sequence s_bad_wr;
    wr_en_in && (wr_addr_in == 16'h0000 || wr_addr_in > COIL_LAST);
  endsequence
  sequence s_err_ans;
    addr_err_out && !wr_ack_out;
  endsequence
  AST_WR_ERR: assert property (s_bad_wr |=> s_err_ans)
    else $error("bad write not flagged");
  AST_WR_ACK: assert property (wr_en_in && !rd_en_in &&
    wr_addr_in != 16'h0000 && wr_addr_in <= COIL_LAST
    |=> wr_ack_out && !addr_err_out) else $error("write not accepted");
  AST_RD_ACK: assert property (rd_ack_out == $past(rd_en_in))
    else $error("read ack wrong");
  AST_RD_ERR: assert property (rd_en_in && rd_addr_in == 16'h0000
    |=> rd_ack_out && !rd_data_out && addr_err_out)
    else $error("bad read not flagged");
  AST_STOP_A: assert property (act_pulse_out[ACT_STOP_A] |->
    $past(wr_en_in, 2) && $past(wr_data_in, 2) &&
    $past(wr_addr_in, 2) == 16'h00f0) else $error("stray stop pulse");
  AST_ONCE: assert property ((act_pulse_out &
    $past(act_pulse_out)) == '0) else $error("pulse too long");
  AST_FRO_SET: assert property (wr_en_in && wr_addr_in == 16'h00f8
    |=> fro_a_out == $past(wr_data_in)) else $error("override a wrong");
  AST_FRO_HOLD: assert property (!(wr_en_in &&
    wr_addr_in == 16'h00f8) |=> $stable(fro_a_out))
    else $error("override a moved");
  AST_MAN_B: assert property (wr_en_in && wr_addr_in == 16'h0125
    |=> manual_b_out == $past(wr_data_in)) else $error("manual b wrong");
  AST_FRO_B: assert property (wr_en_in && wr_addr_in == 16'h00f9
    |=> fro_b_out == $past(wr_data_in)) else $error("override b wrong");
  AST_MAN_A: assert property (wr_en_in && wr_addr_in == 16'h0124
    |=> manual_a_out == $past(wr_data_in)) else $error("manual a wrong");
  AST_RSV: assert property (wr_en_in && wr_addr_in == 16'h0118
    |-> ##2 act_pulse_out == '0) else $error("reserved coil acted");
endmodule

// ===== test/mcc_host_model.sv
`timescale 1ns/10ps
module mcc_host_model
  import mcc_pkg::*;
(
  input  wire logic         clk_in,      // system clock
  input  wire logic         rd_data_in,  // coil read value
  input  wire logic         rd_ack_in,   // read answered
  output logic              wr_en_out,   // write strobe
  output logic [COIL_AW-1:0] wr_addr_out, // write address
  output logic              wr_data_out, // write value
  output logic              rd_en_out,   // read strobe
  output logic [COIL_AW-1:0] rd_addr_out  // read address
);
  // idle bus from time zero
  initial begin
    wr_en_out   = 1'b0;
    wr_addr_out = 16'h0000;
    wr_data_out = 1'b0;
    rd_en_out   = 1'b0;
    rd_addr_out = 16'h0000;
  end
  // one coil write, a one requests the action
  task automatic wr(input int a, input logic d);
    @(negedge clk_in);
    wr_en_out   = 1'b1;
    wr_addr_out = a[15:0];
    wr_data_out = d;
    @(negedge clk_in);
    wr_en_out = 1'b0;
  endtask
  // one coil read, answer taken a cycle later
  task automatic rd(input int a, output logic d, output logic k);
    @(negedge clk_in);
    rd_en_out   = 1'b1;
    rd_addr_out = a[15:0];
    @(negedge clk_in);
    rd_en_out = 1'b0;
    d = rd_data_in;
    k = rd_ack_in;
  endtask
endmodule

// ===== test/mcc_coil_ctrl_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
  err_total++; $display("unexpected %0t value mismatch", $time); end end
module mcc_coil_ctrl_tb;
  import mcc_pkg::*;
  logic clk_in, rst_in, wr_en_in, wr_data_in, rd_en_in, rd_data_out;
  logic rd_ack_out, wr_ack_out, addr_err_out, d, k;
  logic fro_a_out, fro_b_out, manual_a_out, manual_b_out;
  logic [3:0]         lvl_out;
  logic [COIL_AW-1:0] wr_addr_in, rd_addr_in;
  logic [N_EDGE-1:0]  act_pulse_out;
  int                 err_total, num_checks;
  localparam int CO [N_EDGE] = '{212, 213, 220, 221, 224, 225, 226, 227,
    240, 241, 244, 245, 252, 253, 256, 257, 260, 261, 264, 265, 268, 269,
    272, 273, 300, 301, 302, 303, 304, 305, 306, 310, 311, 312, 313, 314,
    315, 316, 340, 341, 342, 343, 344, 345, 346};
  localparam int LV [4] = '{248, 249, 292, 293};
  localparam int RS [4] = '{214, 280, 283, 519};
  mcc_coil_ctrl i_dut (.clk_in, .rst_in, .wr_en_in, .wr_addr_in,
    .wr_data_in, .rd_en_in, .rd_addr_in, .rd_data_out, .rd_ack_out,
    .wr_ack_out, .addr_err_out, .act_pulse_out, .fro_a_out, .fro_b_out,
    .manual_a_out, .manual_b_out);
  mcc_host_model i_host (.clk_in, .rd_data_in(rd_data_out),
    .rd_ack_in(rd_ack_out), .wr_en_out(wr_en_in), .wr_addr_out(wr_addr_in),
    .wr_data_out(wr_data_in), .rd_en_out(rd_en_in),
    .rd_addr_out(rd_addr_in));
  // level outputs gathered for compact checks
  assign lvl_out = {fro_a_out, fro_b_out, manual_a_out, manual_b_out};
  // verdict and end of run
  task automatic finish_test;
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // 50 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // hang guard, run needs some 12 us
  initial begin
    #100000;
    err_total++;
    finish_test();
  end
  // main sequence
  initial begin
    err_total = 0;
    num_checks = 0;
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    `CHK({lvl_out, act_pulse_out, wr_ack_out, rd_ack_out}, '0)
    // every edge coil: one pulse, none when held, reads back
    for (int i = 0; i < N_EDGE; i++) begin
      i_host.wr(CO[i], 1'b1);
      `CHK(wr_ack_out, 1'b1)
      @(negedge clk_in);
      `CHK(act_pulse_out, 45'h1 << i)
      @(negedge clk_in);
      `CHK(act_pulse_out, 45'h0)
      i_host.wr(CO[i], 1'b1);
      @(negedge clk_in);
      `CHK(act_pulse_out, 45'h0)
      i_host.rd(CO[i], d, k);
      `CHK({k, d}, 2'h3)
      i_host.wr(CO[i], 1'b0);
      @(negedge clk_in);
      `CHK(act_pulse_out, 45'h0)
    end
    // level coils follow the written value
    for (int i = 0; i < 4; i++) begin
      i_host.wr(LV[i], 1'b1);
      `CHK(lvl_out, 4'h8 >> i)
      @(negedge clk_in);
      `CHK(act_pulse_out, 45'h0)
      i_host.wr(LV[i], 1'b0);
      `CHK(lvl_out, 4'h0)
    end
    // reserved and unused coils only store
    for (int i = 0; i < 4; i++) begin
      i_host.wr(RS[i], 1'b1);
      @(negedge clk_in);
      `CHK(act_pulse_out, 45'h0)
      i_host.rd(RS[i], d, k);
      `CHK({k, d}, 2'h3)
    end
    // addresses outside the span
    for (int a = 0; a < 521; a += 520) begin
      i_host.wr(a, 1'b1);
      `CHK({wr_ack_out, addr_err_out}, 2'h1)
      i_host.rd(a, d, k);
      `CHK({k, d, addr_err_out}, 3'h5)
    end
    finish_test();
  end
endmodule
bind mcc_coil_ctrl mcc_monitor i_mon (.clk_in, .rst_in, .wr_en_in,
  .wr_addr_in, .wr_data_in, .rd_en_in, .rd_addr_in, .rd_data_out,
  .rd_ack_out, .wr_ack_out, .addr_err_out, .act_pulse_out, .fro_a_out,
  .fro_b_out, .manual_a_out, .manual_b_out);
